// ### otg_stat_regs.svh
// Register offsets, field positions, reset values and timing counts
// of the OTG status and event flag block.
// Assumes a 10 MHz hclk and a word-wide AHB-Lite register port.
`ifndef OTG_STAT_REGS_SVH
`define OTG_STAT_REGS_SVH

// ****************************************************
// Register byte offsets
// ****************************************************
`define OFS_LINE_STATUS 6'h00
`define OFS_EVENT_FLAGS 6'h04
`define OFS_EVENT_MASK 6'h08
`define OFS_ERR_ENABLE 6'h0C
`define OFS_ERR_STATUS 6'h10

// ****************************************************
// Field positions
// ****************************************************
`define BIT_CABLE_TYPE 7
`define BIT_LINE_STABLE 5
`define BIT_SESSION_VALID 3
`define BIT_B_SESSION_END 2
`define BIT_A_VBUS_OK 0
`define BIT_BUS_QUIET 4
`define BIT_TOKEN_DONE 3
`define BIT_ERROR_SUMMARY 1

// ****************************************************
// Reset values and timing
// ****************************************************
`define RST_BYTE 8'h00
`define RST_WORD 32'h0000_0000
`define CLK_KHZ 10000
`define LINE_STABLE_MS 1
`define BUS_QUIET_MS 3
`define LINE_STABLE_CYCLES (`LINE_STABLE_MS * `CLK_KHZ)
`define BUS_QUIET_CYCLES (`BUS_QUIET_MS * `CLK_KHZ)

`endif

// ### otg_stat_pkg.sv
// Types shared by the OTG status and event flag block.
// Assumes the constants header sits in the same folder.
`default_nettype none
package otg_stat_pkg;

   // ****************************************************
   // Cable and line levels from the transceiver
   // ****************************************************
   typedef struct packed {
      logic cable_type_indicator;
      logic line_se0;
      logic line_j_level;
      logic vbus_session_valid_flag;
   } usb_line_t;

   // ****************************************************
   // Complete state of the block
   // ****************************************************
   typedef struct packed {
      usb_line_t sync1;
      usb_line_t sync2;
      logic [1:0] line_prev;
      logic [15:0] stable_cnt;
      logic line_stable;
      logic [15:0] quiet_cnt;
      logic [7:0] flags;
      logic [7:0] mask;
      logic [7:0] err_stat;
      logic [7:0] err_en;
      logic wr_pend;
      logic [5:0] waddr;
      logic [31:0] rdata;
      logic irq;
      logic advance;
   } state_t;

endpackage
`default_nettype wire

// ### otg_line_status.sv
// OTG line status, event flags, masks and interrupt over AHB-Lite.
// Assumes line pins are asynchronous and event pulses come from hclk logic.
//
// Register access over AHB-Lite and the placing of the registers were left to the implementer.
`include "otg_stat_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module otg_line_status #(
   parameter int unsigned LINE_STABLE_CYCLES = `LINE_STABLE_CYCLES,
   parameter int unsigned BUS_QUIET_CYCLES = `BUS_QUIET_CYCLES
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire otg_stat_pkg::usb_line_t line_pins,
   input wire logic [7:0] hw_events,
   input wire logic [7:0] err_events,
   output logic usb_irq,
   output logic stat_queue_advance
);

   // ****************************************************
   // State
   // ****************************************************
   otg_stat_pkg::state_t state_reg;
   otg_stat_pkg::state_t state_next;
   logic [15:0] stable_last;
   logic [15:0] quiet_last;
   logic a_role;
   logic line_idle;
   logic line_changed;
   logic quiet_event;
   logic [7:0] set_vec;
   logic [7:0] clr_vec;
   logic wr_flags;
   logic err_summary;
   logic addr_sel;

   assign stable_last = 16'(LINE_STABLE_CYCLES - 1);
   assign quiet_last = 16'(BUS_QUIET_CYCLES - 1);

   // ****************************************************
   // Decoded conditions
   // ****************************************************
   // An ID pin pulled low by an A plug makes this end the A device
   assign a_role = ~state_reg.sync2.cable_type_indicator;
   // Full-speed idle is J with no SE0
   assign line_idle = state_reg.sync2.line_j_level & ~state_reg.sync2.line_se0;
   assign line_changed = state_reg.line_prev !=
                         {state_reg.sync2.line_se0, state_reg.sync2.line_j_level};
   assign quiet_event = line_idle && (state_reg.quiet_cnt == quiet_last);
   assign wr_flags = state_reg.wr_pend && (state_reg.waddr == `OFS_EVENT_FLAGS);
   assign err_summary = |(state_reg.err_stat & state_reg.err_en);
   assign addr_sel = hsel && hready && htrans[1];

   always_comb
   begin
      set_vec = hw_events;
      set_vec[`BIT_BUS_QUIET] = quiet_event;
      set_vec[`BIT_ERROR_SUMMARY] = 1'b0;
      clr_vec = wr_flags ? hwdata[7:0] : 8'h00;
      clr_vec[`BIT_ERROR_SUMMARY] = 1'b0;
   end

   function automatic logic [31:0] read_word(input logic [5:0] addr,
                                             input otg_stat_pkg::state_t s,
                                             input otg_stat_pkg::usb_line_t pins,
                                             input logic esum);
      logic [31:0] w;
      w = `RST_WORD;
      case (addr)
         `OFS_LINE_STATUS:
         begin
            w[`BIT_CABLE_TYPE] = pins.cable_type_indicator;
            w[`BIT_LINE_STABLE] = s.line_stable;
            w[`BIT_SESSION_VALID] = pins.vbus_session_valid_flag;
            w[`BIT_B_SESSION_END] = pins.cable_type_indicator
                                    & ~pins.vbus_session_valid_flag;
            w[`BIT_A_VBUS_OK] = ~pins.cable_type_indicator
                                & pins.vbus_session_valid_flag;
         end
         `OFS_EVENT_FLAGS:
         begin
            w[7:0] = s.flags;
            w[`BIT_ERROR_SUMMARY] = esum;
         end
         `OFS_EVENT_MASK: w[7:0] = s.mask;
         `OFS_ERR_ENABLE: w[7:0] = s.err_en;
         `OFS_ERR_STATUS: w[7:0] = s.err_stat;
         default: w = `RST_WORD;
      endcase
      return w;
   endfunction

   // ****************************************************
   // Next state
   // ****************************************************
   always_comb
   begin
      state_next = state_reg;

      // Pins cross into hclk through two flops
      state_next.sync1 = line_pins;
      state_next.sync2 = state_reg.sync1;

      // Line stability timer
      state_next.line_prev = {state_reg.sync2.line_se0, state_reg.sync2.line_j_level};
      if (line_changed)
      begin
         state_next.stable_cnt = 16'h0000;
         state_next.line_stable = 1'b0;
      end
      else if (state_reg.stable_cnt == stable_last)
      begin
         state_next.line_stable = 1'b1;
      end
      else
      begin
         state_next.stable_cnt = state_reg.stable_cnt + 16'h0001;
      end

      // Idle timer stops at its end so one idle stretch raises one event
      if (!line_idle)
      begin
         state_next.quiet_cnt = 16'h0000;
      end
      else if (state_reg.quiet_cnt != 16'hFFFF && !quiet_event)
      begin
         state_next.quiet_cnt = state_reg.quiet_cnt + 16'h0001;
      end
      else
      begin
         state_next.quiet_cnt = 16'hFFFF;
      end

      // Set beats clear in the same cycle
      state_next.flags = (state_reg.flags & ~clr_vec) | set_vec;
      state_next.err_stat = state_reg.err_stat | err_events;
      state_next.advance = wr_flags && hwdata[`BIT_TOKEN_DONE]
                           && state_reg.flags[`BIT_TOKEN_DONE];

      // Data phase writes
      if (state_reg.wr_pend)
      begin
         case (state_reg.waddr)
            `OFS_EVENT_MASK: state_next.mask = hwdata[7:0];
            `OFS_ERR_ENABLE: state_next.err_en = hwdata[7:0];
            `OFS_ERR_STATUS:
            begin
               state_next.err_stat = (state_reg.err_stat & ~hwdata[7:0])
                                     | err_events;
            end
            default:
            begin
               state_next.mask = state_next.mask;
            end
         endcase
      end

      // Address phase; read data is built from the updated values so a
      // read right after a write sees the write
      state_next.wr_pend = addr_sel && hwrite;
      state_next.waddr = addr_sel ? haddr[5:0] : state_reg.waddr;
      if (addr_sel && !hwrite)
      begin
         // Pin levels come from the second sync flop only; the first may be metastable
         state_next.rdata = read_word(haddr[5:0], state_next, state_reg.sync2,
                                      |(state_next.err_stat & state_next.err_en));
      end
      else
      begin
         state_next.rdata = `RST_WORD;
      end

      // Error summary is recomputed for the interrupt; bit 1 of the mask gates it
      state_next.irq = |(state_next.flags & state_next.mask)
                       | (state_next.mask[`BIT_ERROR_SUMMARY]
                          & |(state_next.err_stat & state_next.err_en));
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // ****************************************************
   // Outputs
   // ****************************************************
   // Zero wait states; every transfer answers OKAY
   assign hrdata = state_reg.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign usb_irq = state_reg.irq;
   assign stat_queue_advance = state_reg.advance;

   // ****************************************************
   // Checks
   // ****************************************************
   logic rd_status_q;
   logic [7:0] clr_q;
   logic [7:0] set_q;
   logic rd_flags_q;
   logic rd_any_q;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rd_status_q <= 1'b0;
         rd_flags_q <= 1'b0;
         rd_any_q <= 1'b0;
         clr_q <= 8'h00;
         set_q <= 8'h00;
      end
      else
      begin
         rd_status_q <= addr_sel && !hwrite && (haddr[5:0] == `OFS_LINE_STATUS);
         rd_flags_q <= addr_sel && !hwrite && (haddr[5:0] == `OFS_EVENT_FLAGS);
         rd_any_q <= addr_sel && !hwrite;
         clr_q <= clr_vec;
         set_q <= set_vec;
      end
   end

   cable_bit_a: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_status_q |-> hrdata[`BIT_CABLE_TYPE] == $past(state_reg.sync2.cable_type_indicator))
      else $error("cable type bit wrong");

   stable_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
      line_changed |=> !state_reg.line_stable && state_reg.stable_cnt == 16'h0000)
      else $error("line stable not cleared on change");

   stable_rise_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(state_reg.line_stable) |-> $past(state_reg.stable_cnt) == stable_last)
      else $error("line stable set early");

   session_bits_a: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_status_q |-> hrdata[`BIT_SESSION_VALID] == $past(state_reg.sync2.vbus_session_valid_flag)
         && hrdata[`BIT_B_SESSION_END] == ($past(state_reg.sync2.cable_type_indicator)
         && !$past(state_reg.sync2.vbus_session_valid_flag))
         && hrdata[`BIT_A_VBUS_OK] == (!$past(state_reg.sync2.cable_type_indicator)
         && $past(state_reg.sync2.vbus_session_valid_flag)))
      else $error("session bits wrong");

   reserved_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_status_q |-> hrdata[31:8] == 24'h000000 && !hrdata[6] && !hrdata[4] && !hrdata[1])
      else $error("reserved status bits not zero");

   w1c_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ##1 ((state_reg.flags & clr_q & ~set_q) == 8'h00)
         && ((state_reg.flags | clr_q) == ($past(state_reg.flags) | set_q | clr_q)))
      else $error("write one to clear misbehaves");

   flag_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
      |set_vec |=> (state_reg.flags & set_q) == set_q)
      else $error("event flag not set");

   queue_advance_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wr_flags && hwdata[`BIT_TOKEN_DONE] && state_reg.flags[`BIT_TOKEN_DONE]
      |=> stat_queue_advance ##1 !stat_queue_advance)
      else $error("queue advance pulse missing");

   quiet_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(state_reg.flags[`BIT_BUS_QUIET]) |-> $past(quiet_event))
      else $error("bus quiet flag without idle time");

   err_summary_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !state_reg.flags[`BIT_ERROR_SUMMARY])
      else $error("error summary stored as writable flag");

   irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
      |(state_reg.flags & state_reg.mask) |-> usb_irq)
      else $error("interrupt not raised");

   // ****************************************************
   // Role, timer, error and bus checks
   // ****************************************************

   role_b_end_a: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_status_q && hrdata[`BIT_B_SESSION_END] |-> !$past(a_role))
      else $error("session end shown in A role");

   role_a_vbus_a: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_status_q && hrdata[`BIT_A_VBUS_OK] |-> $past(a_role))
      else $error("A VBUS valid shown in B role");

   stable_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      state_reg.line_stable |-> state_reg.stable_cnt == stable_last)
      else $error("line stable without full count");

   stable_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
      state_reg.line_stable && !line_changed |=> state_reg.line_stable)
      else $error("line stable dropped without change");

   quiet_rearm_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !line_idle |=> state_reg.quiet_cnt == 16'h0000)
      else $error("idle timer not restarted");

   quiet_once_a: assert property (@(posedge hclk) disable iff (!hresetn)
      quiet_event |=> state_reg.quiet_cnt == 16'hFFFF && !quiet_event)
      else $error("idle timer raised twice");

   advance_cause_a: assert property (@(posedge hclk) disable iff (!hresetn)
      stat_queue_advance |-> clr_q[`BIT_TOKEN_DONE] && $past(state_reg.flags[`BIT_TOKEN_DONE]))
      else $error("queue advanced without token done clear");

   err_latch_a: assert property (@(posedge hclk) disable iff (!hresetn)
      |err_events |=> (state_reg.err_stat & $past(err_events)) == $past(err_events))
      else $error("error condition not latched");

   esum_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_flags_q |-> hrdata[`BIT_ERROR_SUMMARY] == err_summary && hrdata[31:8] == 24'h000000)
      else $error("error summary read wrong");

   irq_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !(|(state_reg.flags & state_reg.mask))
         && !(state_reg.mask[`BIT_ERROR_SUMMARY] && err_summary) |-> !usb_irq)
      else $error("interrupt raised with nothing pending");

   rdata_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !rd_any_q |-> hrdata == 32'h0000_0000)
      else $error("read data outside read data phase");

   mask_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
      state_reg.wr_pend && state_reg.waddr == `OFS_EVENT_MASK
         |=> state_reg.mask == $past(hwdata[7:0]))
      else $error("event mask write lost");

endmodule // otg_line_status
`default_nettype wire

// ### usb_peer_model.sv
// Cable-side peer: cable identity, VBUS comparator and bus line levels.
// Assumes the bench picks the levels; they are asynchronous to hclk.
`timescale 1ns/1ps
`default_nettype none

module usb_peer_model (
   input wire logic cable_b,
   input wire logic vbus_high,
   input wire logic [1:0] line_se0_j,
   output var otg_stat_pkg::usb_line_t line_pins
);
   // SE0 wins over J: both high is no legal bus state
   always_comb
   begin
      line_pins.cable_type_indicator = cable_b;
      line_pins.line_se0 = line_se0_j[1];
      line_pins.line_j_level = line_se0_j[0] & ~line_se0_j[1];
      line_pins.vbus_session_valid_flag = vbus_high;
   end
endmodule // usb_peer_model
`default_nettype wire

// ### usb_otg_status_and_event_flags_bench.sv
// Self-checking bench for the OTG status and event flag block.
// Assumes one AHB-Lite slave, so hready is the slave's hreadyout.
`timescale 1ns/1ps
`default_nettype none

module usb_otg_status_and_event_flags_bench;
   // Short timer counts keep the run brief
   localparam int STABLE = 20;
   localparam int QUIET = 40;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [7:0] hw_events = 8'h00;
   logic [7:0] err_events = 8'h00;
   logic cable_b = 1'b0;
   logic vbus_high = 1'b0;
   logic [1:0] line_se0_j = 2'h0;
   logic hready;
   logic [31:0] hrdata;
   logic hresp;
   logic usb_irq;
   logic adv;
   otg_stat_pkg::usb_line_t line_pins;
   int failures = 0;
   int samples_checked = 0;

   always #50 hclk = ~hclk;

   usb_peer_model peer (.cable_b(cable_b), .vbus_high(vbus_high),
      .line_se0_j(line_se0_j), .line_pins(line_pins));

   otg_line_status #(.LINE_STABLE_CYCLES(STABLE), .BUS_QUIET_CYCLES(QUIET)) uut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .line_pins(line_pins),
      .hw_events(hw_events), .err_events(err_events), .usb_irq(usb_irq),
      .stat_queue_advance(adv));

   // ****************************************************
   // Bus and compare helpers
   // ****************************************************
   task automatic complete_run();
      if (failures == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   // A slave that never answers ends the run
   task automatic wait_ready();
      int n;
      n = 0;
      @(posedge hclk);
      while (hready !== 1'b1)
      begin
         n++;
         if (n > 16)
         begin
            failures++;
            complete_run();
         end
         @(posedge hclk);
      end
   endtask

   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
      output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= {26'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      r = hrdata;
      chk({31'h0, hresp}, 32'h0);
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask

   task automatic rd(input logic [5:0] a, input logic [31:0] exp);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      chk(x, exp);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge hclk);
   endtask

   task automatic pulse(input logic [7:0] hw, input logic [7:0] er);
      hw_events <= hw;
      err_events <= er;
      @(posedge hclk);
      hw_events <= 8'h00;
      err_events <= 8'h00;
      idle(2);
   endtask

   function automatic logic [31:0] stat(input logic c, input logic v, input logic s);
      return {24'h0, c, 1'b0, s, 1'b0, v, c & ~v, 1'b0, ~c & v};
   endfunction

   // ****************************************************
   // Scenarios
   // ****************************************************
   task automatic t_status();
      logic [1:0] i;
      rd(6'h00, 32'h0);
      rd(6'h04, 32'h0);
      rd(6'h20, 32'h0);
      idle(STABLE + 10);
      for (int k = 0; k < 4; k++)
      begin
         i = k[1:0];
         cable_b <= i[1];
         vbus_high <= i[0];
         idle(4);
         rd(6'h00, stat(i[1], i[0], 1'b1));
      end
      wr(6'h00, 32'hFFFF_FFFF);
      rd(6'h00, stat(1'b1, 1'b1, 1'b1));
   endtask

   task automatic t_stable();
      line_se0_j <= 2'b01;
      idle(3);
      rd(6'h00, stat(1'b1, 1'b1, 1'b0));
      idle(STABLE + 5);
      rd(6'h00, stat(1'b1, 1'b1, 1'b1));
      line_se0_j <= 2'b10;
      idle(3);
      rd(6'h00, stat(1'b1, 1'b1, 1'b0));
   endtask

   task automatic t_events();
      wr(6'h08, 32'hFF);
      pulse(8'hFF, 8'h00);
      chk({31'h0, usb_irq}, 32'h1);
      wr(6'h04, 32'h0);
      rd(6'h04, 32'hED);
      wr(6'h04, 32'h08);
      #1 chk({31'h0, adv}, 32'h1);
      @(posedge hclk);
      rd(6'h04, 32'hE5);
      wr(6'h04, 32'hFF);
      idle(2);
      chk({31'h0, usb_irq}, 32'h0);
      wr(6'h08, 32'h0);
      pulse(8'h01, 8'h00);
      chk({31'h0, usb_irq}, 32'h0);
      rd(6'h04, 32'h01);
      wr(6'h04, 32'h01);
      wr(6'h0C, 32'h01);
      pulse(8'h00, 8'h01);
      rd(6'h04, 32'h02);
      wr(6'h04, 32'h02);
      rd(6'h04, 32'h02);
      wr(6'h10, 32'h01);
      idle(2);
      rd(6'h04, 32'h0);
   endtask

   task automatic t_quiet();
      line_se0_j <= 2'b01;
      idle(QUIET - 10);
      rd(6'h04, 32'h0);
      idle(20);
      rd(6'h04, 32'h10);
      wr(6'h04, 32'h10);
      idle(QUIET + 10);
      rd(6'h04, 32'h0);
      wr(6'h08, 32'hFF);
      wr(6'h0C, 32'h01);
      pulse(8'h01, 8'h01);
      chk({31'h0, usb_irq}, 32'h1);
      hresetn <= 1'b0;
      idle(2);
      chk({31'h0, usb_irq}, 32'h0);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(6'h08, 32'h0);
      rd(6'h0C, 32'h0);
      rd(6'h04, 32'h0);
   endtask

   initial
   begin
      idle(2);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_status();
      t_stable();
      t_events();
      t_quiet();
      complete_run();
   end
endmodule // usb_otg_status_and_event_flags_bench
`default_nettype wire
